// ===== pin_mux_pkg.sv
// Notes on behaviour
// - GPIO mode: debug pin output only, input ignored
// - Reset only after low of 100 ns
// - Port B bit 0 bidirectional, switchable pullup
// - Port B bit 0 to timer or converter
// - Keyboard pins: pulldown only with wake enabled
// - Port A bit n drives wake bit n
// - Serial on: port A bit 3 data out
// - Serial on: port A bit 2 data in
// - Serial on: port A bit 1 clock in
// - Serial on: port A bit 0 select, low
// - Debug pin low at reset end: debug
package pin_mux_pkg;
  // APB register byte offsets
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] porta_dir_addr = 8'h04;
  localparam logic [7:0] porta_out_addr = 8'h08;
  localparam logic [7:0] porta_pull_addr = 8'h0C;
  localparam logic [7:0] wake_en_addr = 8'h10;
  localparam logic [7:0] portb_addr = 8'h14;
  localparam logic [7:0] pin_in_addr = 8'h18;
  localparam logic [7:0] irq_status_addr = 8'h1C;
  localparam logic [7:0] irq_enable_addr = 8'h20;
  localparam logic [7:0] irq_clear_addr = 8'h24;
  // Control register fields
  localparam int ctrl_serial_en = 0;
  localparam int ctrl_gpio_mode = 1;
  // Port B register fields
  localparam int pb_dir = 0;
  localparam int pb_out = 1;
  localparam int pb_pullup = 2;
  localparam int pb_sel_lo = 3;
  localparam int pb_sel_hi = 4;
  // Port B function selections
  localparam logic [1:0] pb_fn_gpio = 2'h0;
  localparam logic [1:0] pb_fn_timer = 2'h1;
  localparam logic [1:0] pb_fn_adc = 2'h2;
  // Status bits: wake events 0..3, external reset 4
  localparam int irq_reset_bit = 4;
  localparam int irq_width = 5;
  // Least reset low time and clock rate
  localparam int reset_low_ns = 100;
  localparam int clock_mhz = 250;
  localparam int reset_low_cycles = (reset_low_ns * clock_mhz + 999) / 1000;
endpackage

// ===== reset_qualifier.sv
`timescale 1ns/10ps
// Qualifies the external reset pin: pulse only on a long enough low
module reset_qualifier #(
  parameter int min_cycles = pin_mux_pkg::reset_low_cycles
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin_reset_n,
  output logic reset_pulse
);
  // Saturating count of low cycles
  logic [7:0] low_count;

  // The 8-bit counter saturates at its top, so longer minimums cannot be served
  if (min_cycles < 1 || min_cycles > 254) begin : g_bad_min_cycles
    $error("min_cycles out of range");
  end

  // Count while low, clear when high
  always_ff @(posedge clock) begin
    if (!resetn) begin
      low_count <= 8'h00;
    end else if (!pin_reset_n) begin
      if (low_count != 8'hFF) begin
        low_count <= low_count + 8'h01;
      end
    end else begin
      low_count <= 8'h00;
    end
  end

  // Fire on the rise that ends a qualified low
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reset_pulse <= 1'b0;
    end else begin
      reset_pulse <= pin_reset_n && (low_count >= 8'(min_cycles));
    end
  end

  property p_short_no_reset;
    @(posedge clock) disable iff (!resetn)
      (pin_reset_n && low_count < 8'(min_cycles)) |=> !reset_pulse;
  endproperty
  a_short_no_reset: assert property (p_short_no_reset) else $error("short low reset");
endmodule

// ===== port_pin_function_mux.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
// Pin-function multiplexer for port A, port B and the reset pin
module port_pin_function_mux (
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port A bits 0..3
  input wire logic [3:0] porta_in,
  output logic [3:0] porta_out,
  output logic [3:0] porta_oe,
  output logic [3:0] porta_pullup,
  output logic [3:0] porta_pulldown,
  // Debug-capable bit 4
  input wire logic port_a_bit4_debug_pin_in,
  output logic port_a_bit4_debug_pin_out,
  output logic port_a_bit4_debug_pin_oe,
  output logic background_debug_state,
  // Port B bit 0
  input wire logic port_b_bit0_in,
  output logic port_b_bit0_out,
  output logic port_b_bit0_oe,
  output logic port_b_bit0_pullup,
  // Timer channel and converter input
  input wire logic timer_channel_zero_out,
  input wire logic timer_channel_zero_oe,
  output logic timer_channel_zero_in,
  output logic converter_input_three_en,
  // Serial interface, device side
  input wire logic serial_data_to_host,
  output logic serial_data_from_host,
  output logic serial_clock_from_host,
  output logic serial_select_n,
  // Wake and reset
  output logic [3:0] wake_irq,
  input wire logic pin_reset_n,
  output logic external_reset,
  output logic irq
);
  // Software state
  logic serial_en;
  logic gpio_mode;
  logic [3:0] dir_a;
  logic [4:0] out_a;
  logic [3:0] pull_a;
  logic [3:0] wake_en;
  logic [4:0] portb_cfg;
  logic [4:0] irq_status;
  logic [4:0] irq_enable;
  logic [3:0] wake_prev;
  logic por_done;
  logic reset_pulse;
  logic [4:0] irq_set;
  logic [4:0] irq_clr;

  // Bus strobes
  wire bus_access = psel && penable;
  wire bus_write = bus_access && pwrite;

  // Address is mapped
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      pin_mux_pkg::ctrl_addr, pin_mux_pkg::porta_dir_addr,
      pin_mux_pkg::porta_out_addr, pin_mux_pkg::porta_pull_addr,
      pin_mux_pkg::wake_en_addr, pin_mux_pkg::portb_addr,
      pin_mux_pkg::pin_in_addr, pin_mux_pkg::irq_status_addr,
      pin_mux_pkg::irq_enable_addr, pin_mux_pkg::irq_clear_addr: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Zero-wait slave
  assign pready = 1'b1;
  assign pslverr = bus_access && !mapped(paddr);

  // Control register writes
  always_ff @(posedge clock) begin
    if (!resetn) begin
      serial_en <= 1'b0;
      gpio_mode <= 1'b0;
      dir_a <= 4'h0;
      out_a <= 5'h00;
      pull_a <= 4'h0;
      wake_en <= 4'h0;
      portb_cfg <= 5'h00;
      irq_enable <= 5'h00;
    end else if (bus_write) begin
      case (paddr)
        pin_mux_pkg::ctrl_addr: begin
          serial_en <= pwdata[pin_mux_pkg::ctrl_serial_en];
          gpio_mode <= pwdata[pin_mux_pkg::ctrl_gpio_mode];
        end
        pin_mux_pkg::porta_dir_addr: dir_a <= pwdata[3:0];
        pin_mux_pkg::porta_out_addr: out_a <= pwdata[4:0];
        pin_mux_pkg::porta_pull_addr: pull_a <= pwdata[3:0];
        pin_mux_pkg::wake_en_addr: wake_en <= pwdata[3:0];
        pin_mux_pkg::portb_addr: portb_cfg <= pwdata[4:0];
        pin_mux_pkg::irq_enable_addr: irq_enable <= pwdata[4:0];
        default: begin
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        pin_mux_pkg::ctrl_addr: prdata <= {30'h0, gpio_mode, serial_en};
        pin_mux_pkg::porta_dir_addr: prdata <= {28'h0, dir_a};
        pin_mux_pkg::porta_out_addr: prdata <= {27'h0, out_a};
        pin_mux_pkg::porta_pull_addr: prdata <= {28'h0, pull_a};
        pin_mux_pkg::wake_en_addr: prdata <= {28'h0, wake_en};
        pin_mux_pkg::portb_addr: prdata <= {27'h0, portb_cfg};
        // debug pin input reads zero in GPIO mode
        pin_mux_pkg::pin_in_addr: prdata <= {26'h0, port_b_bit0_in,
          port_a_bit4_debug_pin_in && !gpio_mode, porta_in};
        pin_mux_pkg::irq_status_addr: prdata <= {27'h0, irq_status};
        pin_mux_pkg::irq_enable_addr: prdata <= {27'h0, irq_enable};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Port A pin drive, serial overrides GPIO on bits 0..3
  always_comb begin
    porta_out = out_a[3:0];
    porta_oe = dir_a;
    if (serial_en) begin
      porta_out = {serial_data_to_host, 3'h0};
      porta_oe = 4'h8;
    end
  end

  // Pull devices; pulldown needs wake enable
  always_comb begin
    porta_pullup = serial_en ? 4'h0 : (pull_a & ~wake_en);
    porta_pulldown = serial_en ? 4'h0 : (pull_a & wake_en);
  end

  // Serial inputs from port A
  assign serial_data_from_host = serial_en && porta_in[2];
  assign serial_clock_from_host = serial_en && porta_in[1];
  assign serial_select_n = !serial_en || porta_in[0];

  // Wake inputs: pin n to bit n, blocked while serial owns the pins
  assign wake_irq = serial_en ? 4'h0 : (porta_in & wake_en);

  // Debug pin: output only in GPIO mode
  assign port_a_bit4_debug_pin_out = out_a[4];
  assign port_a_bit4_debug_pin_oe = gpio_mode;

  // Port B bit 0 function routing
  wire [1:0] pb_sel = portb_cfg[pin_mux_pkg::pb_sel_hi:pin_mux_pkg::pb_sel_lo];
  always_comb begin
    port_b_bit0_out = portb_cfg[pin_mux_pkg::pb_out];
    port_b_bit0_oe = portb_cfg[pin_mux_pkg::pb_dir];
    converter_input_three_en = 1'b0;
    unique case (pb_sel)
      pin_mux_pkg::pb_fn_timer: begin
        port_b_bit0_out = timer_channel_zero_out;
        port_b_bit0_oe = timer_channel_zero_oe;
      end
      pin_mux_pkg::pb_fn_adc: begin
        port_b_bit0_oe = 1'b0;
        converter_input_three_en = 1'b1;
      end
      default: begin
      end
    endcase
  end
  assign port_b_bit0_pullup = portb_cfg[pin_mux_pkg::pb_pullup] &&
    (pb_sel != pin_mux_pkg::pb_fn_adc);
  assign timer_channel_zero_in = (pb_sel == pin_mux_pkg::pb_fn_timer) && port_b_bit0_in;

  // Debug strap caught on the first edge after reset release
  always_ff @(posedge clock) begin
    if (!resetn) begin
      por_done <= 1'b0;
      background_debug_state <= 1'b0;
    end else if (!por_done) begin
      por_done <= 1'b1;
      background_debug_state <= !port_a_bit4_debug_pin_in;
    end
  end

  // External reset qualifier
  reset_qualifier #(
    .min_cycles(pin_mux_pkg::reset_low_cycles)
  ) u_reset_qualifier (
    .clock(clock),
    .resetn(resetn),
    .pin_reset_n(pin_reset_n),
    .reset_pulse(reset_pulse)
  );
  assign external_reset = reset_pulse;

  // Wake edge history
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wake_prev <= 4'h0;
    end else begin
      wake_prev <= wake_irq;
    end
  end

  // Sticky status; set wins over clear
  assign irq_set = {reset_pulse, wake_irq & ~wake_prev};
  assign irq_clr = (bus_write && paddr == pin_mux_pkg::irq_clear_addr) ?
    pwdata[4:0] : 5'h00;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_status <= 5'h00;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_status & irq_enable);

  // Checks
  property p_debug_no_input;
    @(posedge clock) disable iff (!resetn)
      gpio_mode |-> port_a_bit4_debug_pin_oe;
  endproperty
  a_debug_no_input: assert property (p_debug_no_input) else $error("debug pin input");

  property p_pulldown_gate;
    @(posedge clock) disable iff (!resetn)
      porta_pulldown != 4'h0 |-> (porta_pulldown & ~wake_en) == 4'h0;
  endproperty
  a_pulldown_gate: assert property (p_pulldown_gate) else $error("pulldown without wake");

  property p_wake_map;
    @(posedge clock) disable iff (!resetn)
      !serial_en |-> wake_irq == (porta_in & wake_en);
  endproperty
  a_wake_map: assert property (p_wake_map) else $error("wake map wrong");

  property p_serial_out;
    @(posedge clock) disable iff (!resetn)
      serial_en |-> porta_oe == 4'h8 && porta_out[3] == serial_data_to_host;
  endproperty
  a_serial_out: assert property (p_serial_out) else $error("serial out wrong");

  property p_serial_in;
    @(posedge clock) disable iff (!resetn)
      serial_en |-> serial_data_from_host == porta_in[2];
  endproperty
  a_serial_in: assert property (p_serial_in) else $error("serial in wrong");

  property p_serial_clk;
    @(posedge clock) disable iff (!resetn)
      serial_en |-> serial_clock_from_host == porta_in[1];
  endproperty
  a_serial_clk: assert property (p_serial_clk) else $error("serial clock wrong");

  property p_serial_sel;
    @(posedge clock) disable iff (!resetn)
      serial_en |-> serial_select_n == porta_in[0];
  endproperty
  a_serial_sel: assert property (p_serial_sel) else $error("select wrong");

  property p_priority;
    @(posedge clock) disable iff (!resetn)
      serial_en |-> wake_irq == 4'h0 && porta_pulldown == 4'h0;
  endproperty
  a_priority: assert property (p_priority) else $error("serial priority lost");

  property p_timer_route;
    @(posedge clock) disable iff (!resetn)
      pb_sel == pin_mux_pkg::pb_fn_timer |-> port_b_bit0_out == timer_channel_zero_out;
  endproperty
  a_timer_route: assert property (p_timer_route) else $error("timer route wrong");

  property p_strap;
    @(posedge clock) disable iff (!resetn)
      !por_done |=> background_debug_state == !$past(port_a_bit4_debug_pin_in);
  endproperty
  a_strap: assert property (p_strap) else $error("debug strap wrong");

  // Pin-input reads in GPIO mode hide the debug pin level
  sequence s_pin_read;
    psel && !penable && !pwrite && paddr == pin_mux_pkg::pin_in_addr;
  endsequence
  property p_gpio_read_mask;
    @(posedge clock) disable iff (!resetn)
      s_pin_read ##0 gpio_mode |=> prdata[4] == 1'b0;
  endproperty
  a_gpio_read_mask: assert property (p_gpio_read_mask) else $error("debug input seen");

  // External reset only right after a low-to-high step of the pin
  property p_reset_after_rise;
    @(posedge clock) disable iff (!resetn)
      external_reset |-> $past(pin_reset_n) && !$past(pin_reset_n, 2);
  endproperty
  a_reset_after_rise: assert property (p_reset_after_rise) else $error("reset without rise");

  // One qualified low gives one pulse, never a level
  property p_reset_single;
    @(posedge clock) disable iff (!resetn)
      external_reset |=> !external_reset;
  endproperty
  a_reset_single: assert property (p_reset_single) else $error("reset pulse too long");

  // Converter use releases the pin: no drive, no pullup
  property p_adc_route;
    @(posedge clock) disable iff (!resetn)
      pb_sel == pin_mux_pkg::pb_fn_adc |->
        converter_input_three_en && !port_b_bit0_oe && !port_b_bit0_pullup;
  endproperty
  a_adc_route: assert property (p_adc_route) else $error("converter route wrong");

  // Timer input stays quiet unless the timer owns the pin
  property p_timer_in_gate;
    @(posedge clock) disable iff (!resetn)
      pb_sel != pin_mux_pkg::pb_fn_timer |-> !timer_channel_zero_in;
  endproperty
  a_timer_in_gate: assert property (p_timer_in_gate) else $error("timer input leaks");

  // Every rising wake input leaves its status bit set, clear or not
  sequence s_wake_rise;
    (wake_irq & ~wake_prev) != 4'h0;
  endsequence
  property p_wake_sticky;
    @(posedge clock) disable iff (!resetn)
      s_wake_rise |=>
        (irq_status[3:0] & $past(wake_irq & ~wake_prev)) == $past(wake_irq & ~wake_prev);
  endproperty
  a_wake_sticky: assert property (p_wake_sticky) else $error("wake status lost");

  // Serial inputs read idle while the serial port is off
  property p_select_idle;
    @(posedge clock) disable iff (!resetn)
      !serial_en |-> serial_select_n && !serial_clock_from_host && !serial_data_from_host;
  endproperty
  a_select_idle: assert property (p_select_idle) else $error("serial idle wrong");

  // Strap level holds until the next reset
  property p_strap_hold;
    @(posedge clock) disable iff (!resetn)
      por_done |=> $stable(background_debug_state);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("debug state moved");
endmodule

// ===== serial_host_model.sv
`timescale 1ns/10ps
// Host controller on the serial pins
module serial_host_model (
  input wire logic clock,
  input wire logic active,
  output logic cs_n,
  output logic sclk,
  output logic mosi
);
  // Clock stands still between frames; data inverts so no stale level
  always @(posedge clock) begin
    cs_n <= !active;
    sclk <= active ? !sclk : 1'h0;
    mosi <= active ? 1'($urandom) : !mosi;
  end
  // Idle levels at start
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    mosi = 1'h0;
  end
endmodule

// ===== tb_port_pin_function_mux.sv
`timescale 1ns/10ps
// Self-checking bench for the pin mux
module tb_port_pin_function_mux;
  logic clock = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ser = 1'h0;
  logic [7:0] paddr = 8'h00; // Bus address
  logic [31:0] pwdata = 32'h0, prdata, q; // Bus data, last read
  logic pready, pslverr, e; // Answer, last error
  logic [3:0] pa = 4'h0, pa_in, pa_out, pa_oe, pa_pu, pa_pd, wake, wk, dr; // Port A
  logic dbg_in = 1'h1, pb_in = 1'h0, tm_out = 1'h0, tm_oe = 1'h0, to_host = 1'h0, rst_n = 1'h1;
  logic dbg_out, dbg_oe, dbg_st, pb_out, pb_oe, pb_pu, tm_in, adc_en, frm, sck, sel_n, ext, irq;
  logic cs_n, sclk, mosi; // Host pins
  logic [2:0] pb; // Random port B fields
  int err_total = 0, checks_done = 0, pulses = 0;
  // 4 ns period
  always #2 clock = !clock;
  // Host owns bits 0..2 in serial mode
  assign pa_in = ser ? {pa[3], mosi, sclk, cs_n} : pa;
  // Count reset pulses
  always @(posedge clock) if (ext === 1'h1) pulses++;
  serial_host_model host (.clock(clock), .active(ser), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
  port_pin_function_mux dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .porta_in(pa_in), .porta_out(pa_out), .porta_oe(pa_oe),
    .porta_pullup(pa_pu), .porta_pulldown(pa_pd), .port_a_bit4_debug_pin_in(dbg_in),
    .port_a_bit4_debug_pin_out(dbg_out), .port_a_bit4_debug_pin_oe(dbg_oe),
    .background_debug_state(dbg_st), .port_b_bit0_in(pb_in), .port_b_bit0_out(pb_out),
    .port_b_bit0_oe(pb_oe), .port_b_bit0_pullup(pb_pu), .timer_channel_zero_out(tm_out),
    .timer_channel_zero_oe(tm_oe), .timer_channel_zero_in(tm_in),
    .converter_input_three_en(adc_en), .serial_data_to_host(to_host),
    .serial_data_from_host(frm), .serial_clock_from_host(sck), .serial_select_n(sel_n),
    .wake_irq(wake), .pin_reset_n(rst_n), .external_reset(ext), .irq(irq));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Reset pin low for n samples
  task automatic rp(input int n);
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (n) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
  endtask
  // Verdict
  task automatic summarize();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h8f3c));
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    apb(1'h0, pin_mux_pkg::ctrl_addr, 32'h0);
    chk(q, 32'h0, "ctrl reset");
    apb(1'h1, 8'hFC, 32'hFFFFFFFF);
    chk(32'(e), 32'h1, "unmapped error");
    apb(1'h0, 8'hFC, 32'h0);
    chk(q, 32'h0, "unmapped read");
    chk(32'(dbg_st), 32'h0, "debug without strap");
    // Pulls, wake mapping, direction
    repeat (4) begin
      wk = 4'($urandom);
      dr = 4'($urandom);
      apb(1'h1, pin_mux_pkg::porta_pull_addr, 32'hF);
      apb(1'h1, pin_mux_pkg::wake_en_addr, 32'(wk));
      apb(1'h1, pin_mux_pkg::porta_dir_addr, 32'(dr));
      apb(1'h1, pin_mux_pkg::porta_out_addr, 32'(dr));
      apb(1'h1, pin_mux_pkg::irq_clear_addr, 32'h1F);
      pa <= 4'hF;
      @(negedge clock);
      chk(32'(pa_pd), 32'(wk), "pulldown");
      chk(32'(pa_pu), {28'h0, ~wk}, "pullup");
      chk(32'(pa_oe), 32'(dr), "dir");
      chk(32'(pa_out), 32'(dr), "gpio out");
      chk(32'(wake), 32'(wk), "wake map");
      apb(1'h0, pin_mux_pkg::irq_status_addr, 32'h0);
      chk(32'(q[3:0]), 32'(wk), "wake status");
      pa <= 4'h0;
    end
    // GPIO mode: debug pin output only
    apb(1'h1, pin_mux_pkg::porta_out_addr, 32'h10);
    apb(1'h1, pin_mux_pkg::ctrl_addr, 32'h2);
    apb(1'h0, pin_mux_pkg::pin_in_addr, 32'h0);
    chk(32'({dbg_oe, dbg_out, q[4]}), 32'h6, "debug pin");
    // Serial on over GPIO and wake
    apb(1'h1, pin_mux_pkg::wake_en_addr, 32'hF);
    ser <= 1'h1;
    apb(1'h1, pin_mux_pkg::ctrl_addr, 32'h1);
    repeat (8) begin
      to_host <= 1'($urandom);
      @(negedge clock);
      chk(32'({sel_n, sck, frm}), 32'({cs_n, sclk, mosi}), "serial in");
      chk(32'({pa_out[3], pa_oe}), 32'({to_host, 4'h8}), "serial out");
      chk(32'(wake), 32'h0, "wake masked");
      @(posedge clock);
    end
    ser <= 1'h0;
    // Port B functions
    for (int s = 0; s < 3; s++) begin
      pb = 3'($urandom);
      {tm_out, tm_oe, pb_in} <= 3'($urandom);
      apb(1'h1, pin_mux_pkg::portb_addr, {27'h0, 2'(s), pb});
      @(negedge clock);
      if (s == 0) chk(32'({pb_oe, pb_out, pb_pu}), 32'({pb[0], pb[1], pb[2]}), "gpio");
      if (s == 1) chk(32'({pb_out, pb_oe, tm_in}), 32'({tm_out, tm_oe, pb_in}), "timer");
      if (s == 2) chk(32'({pb_oe, pb_pu}), 32'h0, "converter pin");
      chk(32'(adc_en), 32'(s == 2), "converter");
    end
    // Reset pin qualification and interrupt
    apb(1'h1, pin_mux_pkg::irq_enable_addr, 32'h10);
    apb(1'h1, pin_mux_pkg::irq_clear_addr, 32'h1F);
    pulses = 0;
    // Corner cases: one sample short, then exactly enough
    rp(pin_mux_pkg::reset_low_cycles - 1);
    chk(32'(pulses), 32'h0, "short low");
    chk(32'(irq), 32'h0, "no irq");
    rp(pin_mux_pkg::reset_low_cycles);
    chk(32'(pulses), 32'h1, "long low");
    chk(32'(irq), 32'h1, "irq set");
    apb(1'h1, pin_mux_pkg::irq_clear_addr, 32'h10);
    @(negedge clock);
    chk(32'(irq), 32'h0, "irq cleared");
    // Debug strap held low across reset release
    @(posedge clock);
    resetn <= 1'h0;
    dbg_in <= 1'h0;
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    repeat (2) @(posedge clock);
    dbg_in <= 1'h1;
    @(negedge clock);
    chk(32'(dbg_st), 32'h1, "debug strap");
    summarize();
  end
endmodule
